/* File: hw/rws_rc_sync.sv */
// synchroniser turning the rc oscillator into a one-cycle tick enable
`timescale 1ns/100ps
module rws_rc_sync (
    // clock and reset
    input wire logic i_clk,
    input wire logic i_srst,
    // raw rc oscillator
    input wire logic i_rc_osc,
    // tick out
    rws_rc_if.src rc
);
    // ==========================================================
    // three-stage synchroniser
    logic [2:0] sync_q; // stage 0 is read only by stage 1
    logic last_q; // last agreed level

    // shift register
    always_ff @(posedge i_clk)
    begin
        if (i_srst)
            sync_q <= 3'h0;
        else
            sync_q <= {sync_q[1:0], i_rc_osc};
    end

    // accepted level updates once stages 1 and 2 agree
    always_ff @(posedge i_clk)
    begin
        if (i_srst)
            last_q <= 1'b0;
        else if (sync_q[1] == sync_q[2])
            last_q <= sync_q[2];
    end

    // rising edge of the agreed level is one tick
    assign rc.tick = (sync_q[1] == sync_q[2]) && sync_q[2] && !last_q;
endmodule // rws_rc_sync

/* File: hw/rws_seq.sv */
// reset and watchdog sequencer for a small 8-bit core
`timescale 1ns/100ps
`include "rws_consts.svh"
module rws_seq #(
    parameter logic [23:0] POR_TICKS = `RWS_POR_TICKS,
    parameter logic [23:0] WDT_TICKS = `RWS_WDT_TICKS,
    parameter int TRAIL_CYCLES = `RWS_TRAIL_CYCLES
) (
    // clock and reset
    input wire logic i_clk,
    input wire logic i_srst,
    // rc oscillator and supply
    input wire logic i_rc_osc,
    input wire logic i_power_good,
    // core events
    input wire logic i_stop_recover,
    input wire logic i_halt_watchdog_timeout,
    input wire logic i_wdt_instr,
    input wire logic i_halt_mode,
    input wire logic i_stop_mode,
    // configuration option
    input wire logic i_wdt_permanent,
    // core control
    output logic o_core_rst,
    output logic [15:0] o_start_addr,
    output logic o_wdt_running,
    output rws_pkg::rws_src_t o_last_src
);
    import rws_pkg::*;

    // ==========================================================
    // elaboration checks
    if (TRAIL_CYCLES < 1 || TRAIL_CYCLES > 255)
        $error("TRAIL_CYCLES out of range");
    if (POR_TICKS == 24'h0 || WDT_TICKS == 24'h0)
        $error("tick counts must be nonzero");

    localparam logic [7:0] TRAIL_LAST = 8'(TRAIL_CYCLES - 1);
    // first instruction lies just above the vector table
    localparam logic [15:0] START_ADDR = `RWS_START_ADDR;
    if (START_ADDR != 16'(`RWS_VECTOR_BYTES) || `RWS_VECTOR_BYTES != 2 * `RWS_VECTOR_COUNT)
        $error("start address must follow the vector table");

    // ==========================================================
    // rc tick and power-good synchronisation
    rws_rc_if rc_if ();
    rws_rc_sync u_rc_sync (
        .i_clk(i_clk),
        .i_srst(i_srst),
        .i_rc_osc(i_rc_osc),
        .rc(rc_if.src)
    );
    logic rc_tick; // one pulse per rc period
    assign rc_tick = rc_if.tick;

    logic [2:0] pg_sync_q; // power-good synchroniser
    logic pg_q; // agreed power-good level

    // power-good three-stage sync
    always_ff @(posedge i_clk)
    begin
        if (i_srst)
            pg_sync_q <= 3'h0;
        else
            pg_sync_q <= {pg_sync_q[1:0], i_power_good};
    end

    // agreed level changes when stages 1 and 2 match
    always_ff @(posedge i_clk)
    begin
        if (i_srst)
            pg_q <= 1'b0;
        else if (pg_sync_q[1] == pg_sync_q[2])
            pg_q <= pg_sync_q[2];
    end

    logic pg_rise; // bad-to-good transition
    assign pg_rise = (pg_sync_q[1] == pg_sync_q[2]) && pg_sync_q[2] && !pg_q;

    // ==========================================================
    // trigger sources
    logic wdt_timeout; // watchdog terminal count
    logic trigger; // any one-shot start
    assign trigger = pg_rise || i_stop_recover || wdt_timeout || i_halt_watchdog_timeout;

    // ==========================================================
    // sequencer state
    rws_state_t state_q;
    logic [23:0] por_cnt_q; // rc ticks spent in power-on period
    logic [7:0] trail_cnt_q; // system clocks in trailing delay

    // state machine: por -> trail -> run
    always_ff @(posedge i_clk)
    begin
        if (i_srst)
            state_q <= RWS_ST_POR;
        else if (trigger || !pg_q)
            state_q <= RWS_ST_POR; // retrigger restarts one-shot
        else
        begin
            case (state_q)
                RWS_ST_POR:
                    if (rc_tick && por_cnt_q == POR_TICKS - 24'h1)
                        state_q <= RWS_ST_TRAIL;
                RWS_ST_TRAIL:
                    if (trail_cnt_q == TRAIL_LAST)
                        state_q <= RWS_ST_RUN;
                RWS_ST_RUN:
                    state_q <= RWS_ST_RUN;
                default:
                    state_q <= RWS_ST_POR;
            endcase
        end
    end

    // por one-shot counts rc ticks only
    always_ff @(posedge i_clk)
    begin
        if (i_srst || trigger || state_q != RWS_ST_POR)
            por_cnt_q <= 24'h0;
        else if (rc_tick)
            por_cnt_q <= por_cnt_q + 24'h1;
    end

    // trailing delay in system clocks
    always_ff @(posedge i_clk)
    begin
        if (i_srst || state_q != RWS_ST_TRAIL)
            trail_cnt_q <= 8'h0;
        else
            trail_cnt_q <= trail_cnt_q + 8'h1;
    end

    // ==========================================================
    // watchdog
    logic wdt_en_q; // watchdog armed
    logic [23:0] wdt_cnt_q; // rc ticks since last retrigger
    logic running; // core executing
    logic wdt_freeze; // halt/stop pause when not permanent
    assign running = (state_q == RWS_ST_RUN);
    assign wdt_freeze = (i_halt_mode || i_stop_mode) && !i_wdt_permanent;

    // arming: instruction or permanent option on leaving reset
    always_ff @(posedge i_clk)
    begin
        if (i_srst || !running)
            wdt_en_q <= 1'b0;
        else if (i_wdt_instr || i_wdt_permanent)
            wdt_en_q <= 1'b1;
    end

    // retriggerable one-shot clocked by rc ticks
    always_ff @(posedge i_clk)
    begin
        if (i_srst || !running || i_wdt_instr)
            wdt_cnt_q <= 24'h0;
        else if (wdt_en_q && rc_tick && !wdt_freeze)
            wdt_cnt_q <= wdt_cnt_q + 24'h1;
    end

    assign wdt_timeout = running && wdt_en_q && !i_wdt_instr && !wdt_freeze && rc_tick
        && wdt_cnt_q == WDT_TICKS - 24'h1;

    // ==========================================================
    // source capture
    rws_src_t src_q;

    // remember the cause of the latest one-shot start
    always_ff @(posedge i_clk)
    begin
        if (i_srst)
            src_q <= RWS_SRC_POWER;
        else if (wdt_timeout)
            src_q <= RWS_SRC_WDT;
        else if (i_halt_watchdog_timeout)
            src_q <= RWS_SRC_HALT;
        else if (i_stop_recover)
            src_q <= RWS_SRC_STOP;
        else if (pg_rise)
            src_q <= RWS_SRC_POWER;
    end

    // ==========================================================
    // outputs
    logic core_rst_q; // registered core reset

    // core reset held until sequence ends
    always_ff @(posedge i_clk)
    begin
        if (i_srst)
            core_rst_q <= 1'b1;
        else
            core_rst_q <= !(running && !trigger && pg_q);
    end

    assign o_core_rst = core_rst_q;
    assign o_start_addr = START_ADDR;
    assign o_wdt_running = wdt_en_q;
    assign o_last_src = src_q;
endmodule // rws_seq

/* File: pkg/rws_consts.svh */
// timing and address constants for the reset and watchdog sequencer
`ifndef RWS_CONSTS_SVH
`define RWS_CONSTS_SVH
// system clock period in picoseconds (125 MHz)
`define RWS_CLK_PERIOD_PS 8000
// trailing delay in system clock cycles after the power-on period
`define RWS_TRAIL_CYCLES 18
// first instruction address after reset
`define RWS_START_ADDR 16'h000C
// bytes reserved for interrupt vectors
`define RWS_VECTOR_BYTES 12
// number of 16-bit interrupt vectors
`define RWS_VECTOR_COUNT 6
// power-on period in rc oscillator ticks (default)
`define RWS_POR_TICKS 24'h000400
// watchdog timeout in rc oscillator ticks (default)
`define RWS_WDT_TICKS 24'h000200
`endif

/* File: pkg/rws_pkg.sv */
// types shared by the reset and watchdog sequencer
package rws_pkg;
    // sequencer states, one-hot
    typedef enum logic [2:0] {
        RWS_ST_POR   = 3'b001,
        RWS_ST_TRAIL = 3'b010,
        RWS_ST_RUN   = 3'b100
    } rws_state_t;
    // reasons the one-shot was started
    typedef enum logic [1:0] {
        RWS_SRC_POWER = 2'h0,
        RWS_SRC_STOP  = 2'h1,
        RWS_SRC_WDT   = 2'h2,
        RWS_SRC_HALT  = 2'h3
    } rws_src_t;
endpackage

/* File: pkg/rws_rc_if.sv */
// carrier between the sequencer and its rc tick synchroniser
`timescale 1ns/100ps
interface rws_rc_if;
    logic tick; // one-cycle pulse per rc oscillator rising edge
    modport src (output tick);
    modport dst (input tick);
endinterface

/* File: verif/rws_core_model.sv */
// core model: issues the watchdog instruction while running
`timescale 1ns/100ps
module rws_core_model (
    input wire logic i_clk,
    input wire logic i_core_rst,
    input wire logic i_kick_en,
    output logic o_wdt_instr
);
    int cnt = 0; // cycles since last kick
    // kick every 12 cycles, well inside the timeout
    always @(negedge i_clk)
    begin
        cnt = (i_core_rst || cnt == 11) ? 0 : cnt + 1;
        o_wdt_instr = i_kick_en && !i_core_rst && cnt == 11;
    end
endmodule // rws_core_model

/* File: verif/rws_seq_assertions.sv */
// port-level checker for the reset and watchdog sequencer
`timescale 1ns/100ps
module rws_seq_assertions #(
    parameter logic [23:0] POR_TICKS = 24'h000004,
    parameter logic [23:0] WDT_TICKS = 24'h000008,
    parameter int TRAIL_CYCLES = 18,
    parameter int RC_CYC = 6
) (
    input wire logic i_clk,
    input wire logic i_srst,
    input wire logic i_rc_osc,
    input wire logic i_power_good,
    input wire logic i_stop_recover,
    input wire logic i_halt_watchdog_timeout,
    input wire logic i_wdt_instr,
    input wire logic i_halt_mode,
    input wire logic i_stop_mode,
    input wire logic i_wdt_permanent,
    input wire logic o_core_rst,
    input wire logic [15:0] o_start_addr,
    input wire logic o_wdt_running,
    input wire rws_pkg::rws_src_t o_last_src
);
    import rws_pkg::*;
    int rst_cnt; // cycles core has been held
    int idle_cnt; // live watchdog cycles without a kick
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (i_srst);
    // length of the current reset hold
    always_ff @(posedge i_clk)
        rst_cnt <= (i_srst || !o_core_rst) ? 0 : rst_cnt + 1;
    // watchdog idle time, frozen cases clear it
    always_ff @(posedge i_clk)
        if (!i_srst && o_wdt_running && !o_core_rst && !i_wdt_instr && (i_wdt_permanent || !(i_halt_mode || i_stop_mode)))
            idle_cnt <= idle_cnt + 1;
        else
            idle_cnt <= 0;
    sequence s_rst_halt;
        o_core_rst && o_last_src == RWS_SRC_HALT;
    endsequence
    addr_const_a: assert property (o_start_addr == 16'h000C) else $error("bad start address");
    stop_trig_a: assert property (i_stop_recover |=> o_core_rst && o_last_src == RWS_SRC_STOP)
        else $error("stop recovery did not reset core");
    halt_trig_a: assert property (i_halt_watchdog_timeout |=> s_rst_halt)
        else $error("halt timeout did not reset core");
    power_low_a: assert property (!i_power_good [*5] |=> o_core_rst) else $error("core runs on bad supply");
    hold_min_a: assert property ($fell(o_core_rst) |-> rst_cnt >= TRAIL_CYCLES + (POR_TICKS - 1) * RC_CYC)
        else $error("core released too early");
    instr_arm_a: assert property (i_wdt_instr && !o_core_rst |=> o_wdt_running)
        else $error("watchdog not armed");
    perm_arm_a: assert property ($fell(o_core_rst) && i_wdt_permanent |-> ##[0:1] o_wdt_running)
        else $error("permanent watchdog not armed");
    wdt_expire_a: assert property (idle_cnt <= (WDT_TICKS + 3) * RC_CYC)
        else $error("watchdog never expired");
endmodule // rws_seq_assertions
bind rws_seq rws_seq_assertions #(.POR_TICKS(POR_TICKS), .WDT_TICKS(WDT_TICKS), .TRAIL_CYCLES(TRAIL_CYCLES)) u_chk (
    .i_clk(i_clk), .i_srst(i_srst), .i_rc_osc(i_rc_osc), .i_power_good(i_power_good),
    .i_stop_recover(i_stop_recover), .i_halt_watchdog_timeout(i_halt_watchdog_timeout),
    .i_wdt_instr(i_wdt_instr), .i_halt_mode(i_halt_mode), .i_stop_mode(i_stop_mode),
    .i_wdt_permanent(i_wdt_permanent), .o_core_rst(o_core_rst), .o_start_addr(o_start_addr),
    .o_wdt_running(o_wdt_running), .o_last_src(o_last_src));

/* File: verif/rws_seq_bench.sv */
// self-checking bench for the reset and watchdog sequencer
`timescale 1ns/100ps
module rws_seq_bench;
    import rws_pkg::*;
    logic i_clk = 0, i_srst = 1, i_rc_osc = 0, i_power_good = 0, i_stop_recover = 0;
    logic i_halt_watchdog_timeout = 0, i_halt_mode = 0, i_stop_mode = 0, i_wdt_permanent = 0, kick_en = 0;
    logic i_wdt_instr, o_core_rst, o_wdt_running;
    logic [15:0] o_start_addr;
    rws_src_t o_last_src;
    int mismatches = 0, cmp_count = 0, n;
    initial forever #4 i_clk = ~i_clk;
    // free-running rc, six system clocks a period, edges land on falling clock edges
    initial forever #24 i_rc_osc = ~i_rc_osc;
    rws_seq #(.POR_TICKS(24'h000004), .WDT_TICKS(24'h000008), .TRAIL_CYCLES(18)) u_dut (
        .i_clk(i_clk), .i_srst(i_srst), .i_rc_osc(i_rc_osc), .i_power_good(i_power_good),
        .i_stop_recover(i_stop_recover), .i_halt_watchdog_timeout(i_halt_watchdog_timeout),
        .i_wdt_instr(i_wdt_instr), .i_halt_mode(i_halt_mode), .i_stop_mode(i_stop_mode),
        .i_wdt_permanent(i_wdt_permanent), .o_core_rst(o_core_rst), .o_start_addr(o_start_addr),
        .o_wdt_running(o_wdt_running), .o_last_src(o_last_src));
    rws_core_model u_core (.i_clk(i_clk), .i_core_rst(o_core_rst), .i_kick_en(kick_en), .o_wdt_instr(i_wdt_instr));
    task chk(input logic g, input logic e);
        cmp_count++;
        if (g !== e)
        begin
            mismatches++;
            $display("ERROR %0t bit %b not %b", $time, g, e);
        end
    endtask
    task chk_src(input rws_src_t g, input rws_src_t e);
        cmp_count++;
        if (g !== e)
        begin
            mismatches++;
            $display("ERROR %0t cause %0d not %0d", $time, g, e);
        end
    endtask
    task chk_rng(input int v, input int lo, input int hi);
        cmp_count++;
        if (v < lo || v > hi)
        begin
            mismatches++;
            $display("ERROR %0t hold %0d cycles", $time, v);
        end
    endtask
    task wait_rel(output int c);
        c = 0;
        while (o_core_rst !== 1'h0 && c < 300)
        begin
            @(negedge i_clk);
            c++;
        end
    endtask
    task wait_rst;
        n = 0;
        while (o_core_rst !== 1'h1 && n < 200)
        begin
            @(negedge i_clk);
            n++;
        end
    endtask
    // counts falling edges, over len cycles, at which the core is held
    task cnt_rst(input int len);
        n = 0;
        repeat (len)
        begin
            @(negedge i_clk);
            n += o_core_rst;
        end
    endtask
    task t_power;
        chk(o_core_rst, 1'h1);
        i_power_good = 1;
        wait_rel(n);
        chk_rng(n, 35, 56);
        chk(o_start_addr === 16'h000C, 1'h1);
        chk_src(o_last_src, RWS_SRC_POWER);
        $display("power-on test done");
    endtask
    task t_trig(input rws_src_t s);
        i_stop_recover = (s == RWS_SRC_STOP);
        i_halt_watchdog_timeout = (s == RWS_SRC_HALT);
        @(negedge i_clk);
        i_stop_recover = 0;
        i_halt_watchdog_timeout = 0;
        chk(o_core_rst, 1'h1);
        chk_src(o_last_src, s);
        wait_rel(n);
        chk_rng(n, 30, 55);
        $display("trigger test %0d done", s);
    endtask
    task t_brown;
        i_power_good = 0;
        cnt_rst(8);
        chk(o_core_rst, 1'h1);
        i_power_good = 1;
        wait_rel(n);
        chk_rng(n, 35, 56);
        chk_src(o_last_src, RWS_SRC_POWER);
        $display("brown-out test done");
    endtask
    task t_wdt;
        cnt_rst(150);
        chk(n == 0, 1'h1);
        kick_en = 0;
        i_stop_mode = 1;
        cnt_rst(150);
        chk(n == 0, 1'h1);
        i_stop_mode = 0;
        wait_rst;
        chk(o_core_rst, 1'h1);
        @(negedge i_clk);
        chk_src(o_last_src, RWS_SRC_WDT);
        wait_rel(n);
        chk_rng(n, 30, 55);
        $display("watchdog test done");
    endtask
    task t_perm;
        i_wdt_permanent = 1;
        i_halt_mode = 1;
        t_trig(RWS_SRC_STOP);
        @(negedge i_clk);
        chk(o_wdt_running, 1'h1);
        wait_rst;
        chk(o_core_rst, 1'h1);
        @(negedge i_clk);
        chk_src(o_last_src, RWS_SRC_WDT);
        $display("permanent test done");
    endtask
    task print_verdict;
        $display("comparisons %0d mismatches %0d", cmp_count, mismatches);
        if (mismatches == 0 && cmp_count > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    initial
    begin
        repeat (4) @(negedge i_clk);
        i_srst = 0;
        chk(o_wdt_running, 1'h0);
        t_power;
        kick_en = 1;
        t_trig(RWS_SRC_STOP);
        t_trig(RWS_SRC_HALT);
        t_brown;
        t_wdt;
        t_perm;
        print_verdict;
    end
    initial
    begin
        #40000;
        mismatches++;
        print_verdict;
    end
endmodule // rws_seq_bench
